// [common/eea_pkg.sv]
// eea_pkg: register map, control bit positions and cycle timing for the emulated eeprom controller.
// assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
package eea_pkg;
	// register byte offsets
	localparam logic [5:0] ADDR_OFS   = 6'h00;
	localparam logic [5:0] DATA0_OFS  = 6'h04;
	localparam logic [5:0] CTRL_OFS   = 6'h24;
	localparam logic [5:0] POWER_OFS  = 6'h28;
	localparam logic [5:0] STATUS_OFS = 6'h2C;
	localparam logic [5:0] MASK_OFS   = 6'h30;
	localparam int         DATA_REGS  = 8;

	// control register bit positions
	localparam int RD_TRIG_BIT  = 0;
	localparam int RD_EN_BIT    = 1;
	localparam int WR_TRIG_BIT  = 2;
	localparam int WR_EN_BIT    = 3;
	localparam int ER_TRIG_BIT  = 4;
	localparam int ER_EN_BIT    = 5;
	localparam int TSEL_LSB     = 6;

	// status bit positions
	localparam int ST_RD_DONE   = 0;
	localparam int ST_WR_DONE   = 1;
	localparam int ST_ER_DONE   = 2;
	localparam int ST_FAIL      = 3;
	localparam int ST_W         = 4;

	// reset values
	localparam logic [7:0]      CTRL_RST = 8'h00;
	localparam logic [4:0]      ADDR_RST = 5'h00;
	localparam logic [ST_W-1:0] MASK_RST = 4'h0;

	// timing
	localparam int CLK_MHZ      = 125;
	localparam int BASE_TIME_US = 2000;
	localparam int BASE_CYCLES  = BASE_TIME_US * CLK_MHZ;
	localparam int RD_TIME_NS   = 80;
	localparam int RD_CYCLES    = (RD_TIME_NS * CLK_MHZ + 999) / 1000;

	localparam int WORDS         = 32;
	localparam int UNIT_WORDS    = 4;
	localparam int PAGE_WORDS    = 16;

	typedef enum logic [1:0] {EEA_IDLE, EEA_READ, EEA_WRITE, EEA_ERASE} eea_state_t;

	// Avalon-MM request carried as one bundle
	typedef struct packed {
		logic [5:0]  address;
		logic        read;
		logic        write;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} eea_avm_req_t;
endpackage

// [hw/eea_ctrl.sv]
// eea_ctrl: emulated eeprom access controller with its storage array, Avalon-MM register slave,
// cpu stall output and interrupt. assumes the cpu core halts while cpu_stall is high and
// reports low-power entry on low_power_req.
// Operation
// R1 - write stores four 16-bit data words into unit chosen by address bits 4..2.
// R2 - write starts only if trigger is set the access after setting enable.
// R3 - cpu is halted from write activation until the write cycle ends.
// R4 - hardware clears write trigger when the write cycle completes.
// R5 - read needs address, then read enable, then trigger; cpu stalled during read.
// R6 - read end clears read trigger and loads word into first data pair.
// R7 - read data stays in first data pair until next operation.
// R8 - entering low-power before an operation finishes makes it fail.
// R9 - software clears global interrupt enable around write or erase activation.
// R10 - erase or write trigger must directly follow its matching enable; code accepts a freshly set write or erase enable for either trigger.
// R11 - control bits 7..6 select 2, 4, 8 or 16 ms cycle time.
// R12 - every read needs its own address load and trigger; no auto increment.
// R13 - software should keep write enable cleared when not writing.
// R14 - software polls trigger bit until zero, then may clear control register.
// R15 - triggers ignored without enable; write and erase enables self-clear on finish.
// R16 - erase zeroes a 16-word page selected by address bit 4.
// R17 - software never sets two enable or trigger bits in one access.
// R18 - stall to cpu covers the whole cycle, released as the trigger clears.
module eea_ctrl
	import eea_pkg::*;
#(
	parameter int BASE_CYC = eea_pkg::BASE_CYCLES
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// register bus
	input  wire eea_pkg::eea_avm_req_t  avm_req,
	output logic [31:0]                 avm_readdata,
	output logic                        avm_waitrequest,
	// cpu side
	input  wire logic                   low_power_req,
	output logic                        cpu_stall,
	output logic                        irq
);
	import eea_pkg::*;

	logic [15:0]       mem [WORDS];
	logic [4:0]        ee_address_reg;
	logic [7:0]        data_byte [DATA_REGS];
	logic [7:0]        ee_control_reg;
	logic [ST_W-1:0]   status;
	logic [ST_W-1:0]   mask;
	logic [ST_W-1:0]   events;
	eea_state_t        state;
	logic [31:0]       timer;
	logic              last_was_enable;
	logic              rd_pending;
	logic [1:0]        rd_wait;
	logic [31:0]       cycle_len;

	wire acc      = avm_req.read | avm_req.write;
	wire wr_ok    = avm_req.write & avm_req.byteenable[0];
	wire busy     = state != EEA_IDLE;
	wire [7:0] wb = avm_req.writedata[7:0];
	wire wr_ctrl  = wr_ok && avm_req.address == CTRL_OFS;
	wire wr_any   = avm_req.write && !avm_waitrequest;

	// one-hot write into a data byte register
	function automatic logic is_data(input logic [5:0] a, input int i);
		return a == DATA0_OFS + 6'(4 * i);
	endfunction

	// R3 cpu halt
	// R18 stall span
	assign cpu_stall = busy;
	// reads wait two cycles before they are accepted; writes are accepted at once unless a cycle is running
	assign avm_waitrequest = busy ? acc : (avm_req.read & ~rd_wait[1]);
	assign irq = |(status & mask);

	// R11 time select
	always_comb begin
		cycle_len = BASE_CYC << ee_control_reg[TSEL_LSB +: 2];
	end

	always_ff @(posedge clk) begin
		if (rst)
			rd_wait <= 2'b00;
		else if (avm_req.read && !busy && !rd_wait[1])
			rd_wait <= {rd_wait[0], 1'b1};
		else
			rd_wait <= 2'b00;
	end

	logic              wr_addr_sel;
	logic              wr_mask_sel;
	logic              wr_stat_sel;
	logic              fresh_enable;
	logic              start_rd;
	logic              start_wr;
	logic              start_er;
	logic [7:0]        next_ctrl;

	wire ctrl_take = wr_any && wr_ctrl && !busy;
	wire abort     = busy && low_power_req;
	wire done      = busy && timer == 32'h0000_0001 && !low_power_req;
	wire stop      = abort || done;

	// a trigger bit that goes from zero to one in this control write
	function automatic logic rises(input logic [7:0] nv, input logic [7:0] ov, input int b);
		return nv[b] && !ov[b];
	endfunction

	// an enable bit that was already set and is kept set by the trigger write
	function automatic logic kept(input logic [7:0] nv, input logic [7:0] ov, input int b);
		return nv[b] && ov[b];
	endfunction

	// register readback; unmapped offsets read as zero
	function automatic logic [31:0] read_value(input logic [5:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			ADDR_OFS:   v[4:0] = ee_address_reg;
			CTRL_OFS:   v[7:0] = ee_control_reg;
			STATUS_OFS: v[ST_W-1:0] = status;
			MASK_OFS:   v[ST_W-1:0] = mask;
			default: begin
				for (int i = 0; i < DATA_REGS; i++)
					if (is_data(a, i))
						v[7:0] = data_byte[i];
			end
		endcase
		return v;
	endfunction

	always_ff @(posedge clk) begin
		if (rst)
			avm_readdata <= 32'h0000_0000;
		else if (avm_req.read)
			avm_readdata <= read_value(avm_req.address);
	end

	// bus write strobes, one per plain register that a write can reach
	always_comb begin
		wr_addr_sel = 1'b0;
		wr_mask_sel = 1'b0;
		wr_stat_sel = 1'b0;
		if (wr_any && wr_ok) begin
			case (avm_req.address)
				ADDR_OFS:   wr_addr_sel = 1'b1;
				MASK_OFS:   wr_mask_sel = 1'b1;
				STATUS_OFS: wr_stat_sel = 1'b1;
				default:    wr_addr_sel = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			ee_address_reg <= ADDR_RST;
		else if (wr_addr_sel)
			ee_address_reg <= wb[4:0];
	end

	always_ff @(posedge clk) begin
		if (rst)
			mask <= MASK_RST;
		else if (wr_mask_sel)
			mask <= wb[ST_W-1:0];
	end

	// R2 consecutive enable then trigger
	// R10 trigger follows enable
	// only accepted writes count, so any other write between the two steps breaks the pair
	always_comb begin
		fresh_enable = 1'b0;
		if (wr_ctrl) begin
			fresh_enable = fresh_enable | (wb[WR_EN_BIT] & ~ee_control_reg[WR_EN_BIT]);
			fresh_enable = fresh_enable | (wb[ER_EN_BIT] & ~ee_control_reg[ER_EN_BIT]);
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			last_was_enable <= 1'b0;
		else if (wr_any)
			last_was_enable <= fresh_enable;
	end

	// R5 read start
	// R15 trigger needs enable
	// only the lowest rising trigger is looked at; two at once is a software error
	always_comb begin
		start_rd = 1'b0;
		start_wr = 1'b0;
		start_er = 1'b0;
		if (ctrl_take) begin
			if (rises(wb, ee_control_reg, RD_TRIG_BIT))
				start_rd = kept(wb, ee_control_reg, RD_EN_BIT);
			else if (rises(wb, ee_control_reg, WR_TRIG_BIT))
				start_wr = kept(wb, ee_control_reg, WR_EN_BIT) && last_was_enable;
			else if (rises(wb, ee_control_reg, ER_TRIG_BIT))
				start_er = kept(wb, ee_control_reg, ER_EN_BIT) && last_was_enable;
		end
	end

	// R4 write trigger clear
	// R15 enable self-clear
	always_comb begin
		next_ctrl = ee_control_reg;
		if (stop) begin
			case (state)
				EEA_WRITE: begin
					next_ctrl[WR_TRIG_BIT] = 1'b0;
					next_ctrl[WR_EN_BIT]   = 1'b0;
				end
				EEA_ERASE: begin
					next_ctrl[ER_TRIG_BIT] = 1'b0;
					next_ctrl[ER_EN_BIT]   = 1'b0;
				end
				default: next_ctrl[RD_TRIG_BIT] = 1'b0;
			endcase
		end else if (ctrl_take) begin
			next_ctrl = wb;
			// a refused trigger reads back as zero, so polling software never waits on it
			if (rises(wb, ee_control_reg, RD_TRIG_BIT))
				next_ctrl[RD_TRIG_BIT] = start_rd;
			else if (rises(wb, ee_control_reg, WR_TRIG_BIT))
				next_ctrl[WR_TRIG_BIT] = start_wr;
			else if (rises(wb, ee_control_reg, ER_TRIG_BIT))
				next_ctrl[ER_TRIG_BIT] = start_er;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			ee_control_reg <= CTRL_RST;
		else
			ee_control_reg <= next_ctrl;
	end

	// R8 low-power abort
	// a cycle cut by low-power entry ends at once; its target is left as it was
	always_ff @(posedge clk) begin
		if (rst)
			state <= EEA_IDLE;
		else begin
			case (state)
				EEA_IDLE: begin
					if (start_rd)
						state <= EEA_READ;
					else if (start_wr)
						state <= EEA_WRITE;
					else if (start_er)
						state <= EEA_ERASE;
				end
				default: begin
					if (stop)
						state <= EEA_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			timer <= 32'h0000_0000;
		else begin
			case (state)
				EEA_IDLE: begin
					if (start_rd)
						timer <= 32'(RD_CYCLES);
					else if (start_wr || start_er)
						timer <= cycle_len;
				end
				default: timer <= timer - 32'h0000_0001;
			endcase
		end
	end

	// R1 unit write
	// R16 page erase
	// the array is only touched on a clean finish, so an aborted cycle leaves old contents
	for (genvar w = 0; w < WORDS; w++) begin : g_word
		localparam logic [2:0] UNIT = 3'(w / UNIT_WORDS);
		localparam logic       PAGE = 1'(w / PAGE_WORDS);
		localparam int         LANE = w % UNIT_WORDS;
		always_ff @(posedge clk) begin
			if (done && state == EEA_WRITE && ee_address_reg[4:2] == UNIT)
				mem[w] <= {data_byte[2*LANE+1], data_byte[2*LANE]};
			else if (done && state == EEA_ERASE && ee_address_reg[4] == PAGE)
				mem[w] <= 16'h0000;
		end
	end

	// R6 read result
	// R7 data held
	for (genvar g = 0; g < DATA_REGS; g++) begin : g_data
		always_ff @(posedge clk) begin
			if (rst)
				data_byte[g] <= 8'h00;
			else if (done && state == EEA_READ && g < 2)
				data_byte[g] <= mem[ee_address_reg][8*(g%2) +: 8];
			else if (wr_any && wr_ok && is_data(avm_req.address, g))
				data_byte[g] <= wb;
		end
	end

	always_comb begin
		events = '0;
		events[ST_FAIL] = abort;
		if (done) begin
			case (state)
				EEA_READ:  events[ST_RD_DONE] = 1'b1;
				EEA_WRITE: events[ST_WR_DONE] = 1'b1;
				EEA_ERASE: events[ST_ER_DONE] = 1'b1;
				default:   events[ST_FAIL] = abort;
			endcase
		end
	end

	// set beats write-one-to-clear, so an event in the clearing cycle is never lost
	always_ff @(posedge clk) begin
		if (rst)
			status <= '0;
		else if (wr_stat_sel)
			status <= (status & ~wb[ST_W-1:0]) | events;
		else
			status <= status | events;
	end
endmodule

// [sim/eea_ctrl_monitor.sv]
// eea_ctrl_monitor: port checks for eea_ctrl.
// assumes one clock domain; bound at the foot.
module eea_ctrl_monitor
	import eea_pkg::*;
#(
	parameter int BASE_CYC = 20
) (
	// watched ports
	input wire logic                  clk,
	input wire logic                  rst,
	input wire eea_pkg::eea_avm_req_t avm_req,
	input wire logic                  avm_waitrequest,
	input wire logic                  low_power_req,
	input wire logic                  cpu_stall,
	input wire logic                  irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       ctl;
	logic       ab;
	logic [7:0] prev;
	int         cnt;
	int         len;
	assign ctl = avm_req.write && !avm_waitrequest && avm_req.address == CTRL_OFS;
	always_ff @(posedge clk)
		if (rst || avm_req.write && !avm_waitrequest)
			prev <= ctl && !rst ? avm_req.writedata[7:0] : 8'h00;
	// aborted cycles end early, so their length is not judged
	always_ff @(posedge clk) begin
		if (ctl)
			len <= avm_req.writedata[0] ? RD_CYCLES : BASE_CYC << avm_req.writedata[7:6];
		cnt <= cpu_stall ? cnt + 1 : 0;
		ab <= cpu_stall && (ab || low_power_req);
	end
	default clocking dcb @(posedge clk); endclocking
	default disable iff (rst);
	a_reset_clean: assert property ($fell(rst) |-> !cpu_stall && !irq) else $error("reset");
	a_write_go: assert property (ctl && avm_req.writedata[2] && prev[3] && !prev[2] |=> cpu_stall) else $error("go");
	a_stall_cause: assert property ($rose(cpu_stall) |-> $past(ctl && avm_req.writedata[4:0] != 5'h00)) else $error("cause");
	a_bus_halted: assert property (cpu_stall && (avm_req.read || avm_req.write) |-> avm_waitrequest) else $error("halt");
	a_write_quick: assert property (avm_req.write && !cpu_stall |-> !avm_waitrequest) else $error("resume");
	a_read_wait: assert property ($rose(avm_req.read) && !cpu_stall |-> avm_waitrequest [*2] ##1 !avm_waitrequest) else $error("rd");
	a_cycle_len: assert property ($fell(cpu_stall) && !ab && !low_power_req |-> cnt == len) else $error("len");
	a_abort_quick: assert property (low_power_req && cpu_stall |-> ##[1:2] !cpu_stall) else $error("abort");
	c_done: cover property ($fell(cpu_stall) && !ab);
	c_abort: cover property (low_power_req && cpu_stall);
	c_irq: cover property ($rose(irq));
endmodule
bind eea_ctrl eea_ctrl_monitor #(.BASE_CYC(BASE_CYC)) i_mon (.clk(clk), .rst(rst), .avm_req(avm_req),
	.avm_waitrequest(avm_waitrequest), .low_power_req(low_power_req), .cpu_stall(cpu_stall), .irq(irq));

// [sim/eea_cpu_model.sv]
// eea_cpu_model: cpu core as Avalon-MM master of eea_ctrl.
// one access at a time, an idle edge after each.
module eea_cpu_model
	import eea_pkg::*;
(
	// bus and power
	input  wire logic           clk,
	input  wire logic [31:0]    avm_readdata,
	input  wire logic           avm_waitrequest,
	output eea_pkg::eea_avm_req_t avm_req,
	output logic                low_power_req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {avm_req, low_power_req} = '0;
	// request held until the rising edge that sees waitrequest low; data taken at that edge
	task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
		avm_req <= '{a, !w, w, 4'hf, 32'(d)};
		do
			@(posedge clk);
		while (avm_waitrequest !== 1'b0);
		q = avm_readdata[7:0];
		avm_req <= '0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, a, d, q);
	endtask
	// no interrupt is serviced between the two steps
	task automatic start(input logic [7:0] en, input logic [7:0] trig);
		wr(CTRL_OFS, en);
		wr(CTRL_OFS, en | trig);
	endtask
	task automatic poll(output logic [7:0] c);
		do
			acc(1'b0, CTRL_OFS, 8'h00, c);
		while ((c & 8'h15) != 8'h00);
	endtask
	task automatic rd_word(input logic [7:0] a, output logic [7:0] lo, output logic [7:0] hi);
		wr(ADDR_OFS, a);
		start(8'h02, 8'h01);
		poll(lo);
		acc(1'b0, DATA0_OFS, 8'h00, lo);
		acc(1'b0, DATA0_OFS + 6'h04, 8'h00, hi);
		wr(CTRL_OFS, 8'h00);
	endtask
	task automatic sleep();
		low_power_req <= 1'b1;
		@(posedge clk);
		low_power_req <= 1'b0;
	endtask
endmodule

// [sim/eea_ctrl_tb.sv]
// eea_ctrl_tb: bench for eea_ctrl driven by the cpu model.
// base cycle count cut to 20 to keep runs short.
module eea_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import eea_pkg::*;
	localparam int BASE = 20;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	eea_avm_req_t avm_req;
	logic [31:0]  avm_readdata;
	logic         avm_waitrequest;
	logic         low_power_req;
	logic         cpu_stall;
	logic         irq;
	logic [7:0]   lo;
	logic [7:0]   hi;
	int           failures = 0;
	int           samples_checked = 0;
	int           stalls = 0;
	int           cycles = 0;
	eea_ctrl #(.BASE_CYC(BASE)) i_dut (.*);
	eea_cpu_model i_cpu (.*);
	always #4 clk = ~clk;
	always @(posedge clk) begin
		stalls <= stalls + int'(cpu_stall === 1'b1);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			complete_run();
		end
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic complete_run();
		if (failures == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic t_reset();
		logic [5:0] ofs [6] = '{ADDR_OFS, DATA0_OFS, CTRL_OFS, POWER_OFS, STATUS_OFS, MASK_OFS};
		i_cpu.wr(POWER_OFS, 8'hff);
		foreach (ofs[i]) begin
			i_cpu.acc(1'b0, ofs[i], 8'h00, lo);
			chk("reset", 8'h00, lo);
		end
	endtask
	task automatic t_write();
		int s;
		for (int k = 0; k < 8; k++)
			i_cpu.wr(DATA0_OFS + 6'(4 * k), 8'ha0 + 8'(k));
		i_cpu.wr(ADDR_OFS, 8'h07);
		s = stalls;
		i_cpu.start(8'h08, 8'h04);
		i_cpu.poll(lo);
		chk("ctrl", 8'h00, lo);
		chk("stall", 8'(BASE), 8'(stalls - s));
		for (int j = 0; j < 4; j++) begin
			i_cpu.rd_word(8'(4 + j), lo, hi);
			chk("low", 8'ha0 + 8'(2 * j), lo);
			chk("high", 8'ha1 + 8'(2 * j), hi);
		end
		i_cpu.wr(ADDR_OFS, 8'h00);
		i_cpu.acc(1'b0, DATA0_OFS, 8'h00, lo);
		chk("held", 8'ha6, lo);
	endtask
	task automatic t_refuse();
		int s;
		s = stalls;
		i_cpu.wr(CTRL_OFS, 8'h08);
		i_cpu.wr(ADDR_OFS, 8'h04);
		i_cpu.wr(CTRL_OFS, 8'h0c);
		i_cpu.wr(CTRL_OFS, 8'h04);
		i_cpu.acc(1'b0, CTRL_OFS, 8'h00, lo);
		chk("ctrl", 8'h00, lo);
		chk("stall", 8'h00, 8'(stalls - s));
	endtask
	task automatic t_erase();
		int s;
		for (int t = 0; t < 4; t++) begin
			s = stalls;
			i_cpu.wr(ADDR_OFS, 8'h0f);
			i_cpu.start(8'(t << 6) | 8'h20, 8'h10);
			i_cpu.poll(lo);
			chk("ctrl", 8'(t << 6), lo);
			chk("stall", 8'(BASE << t), 8'(stalls - s));
		end
		i_cpu.rd_word(8'h07, lo, hi);
		chk("erased", 8'h00, lo);
		chk("erased", 8'h00, hi);
	endtask
	task automatic t_abort();
		i_cpu.wr(STATUS_OFS, 8'h0f);
		i_cpu.wr(MASK_OFS, 8'h0f);
		i_cpu.start(8'h08, 8'h04);
		i_cpu.sleep();
		i_cpu.acc(1'b0, STATUS_OFS, 8'h00, lo);
		chk("status", 8'h08, lo);
		chk("irq", 8'h01, 8'(irq));
		i_cpu.wr(MASK_OFS, 8'h07);
		chk("masked", 8'h00, 8'(irq));
		i_cpu.wr(STATUS_OFS, 8'h08);
		i_cpu.wr(MASK_OFS, 8'h0f);
		chk("cleared", 8'h00, 8'(irq));
		i_cpu.rd_word(8'h05, lo, hi);
		chk("kept", 8'h00, lo);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_write();
		t_refuse();
		t_erase();
		t_abort();
		complete_run();
	end
endmodule
